// file: bench/local_to_vme_map_decode_tb.sv
/*
  Self-checking testbench for the outbound map decode stage: register access,
  segment and fixed window decode, translation and reset values.
  Assumes the package and design files compile ahead of this file.
*/
module local_to_vme_map_decode_tb
  import map_decode_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_i;
  logic rstn_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  local_cycle_t local_i;
  vme_cycle_t vme_o;
  logic [31:0] taken;
  int bad_count = 0;
  int num_checks = 0;
  int exp_starts = 0;

  local_to_vme_map_decode local_to_vme_map_decode_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .local_i(local_i), .vme_o(vme_o));
  vme_slave_model vme_slave_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .vme_i(vme_o),
    .taken_o(taken), .last_o());

  // ----------------------------------------------------------------------
  // Comparison and bus tasks.
  // ----------------------------------------------------------------------
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  // An unclaimed cycle leaves the other fields open, so only start and decoder are judged.
  task automatic check_vme(input string what, input vme_cycle_t exp, input vme_cycle_t got);
    num_checks++;
    if (exp.start ? (got !== exp) : (got.start !== 1'b0 || got.decoder !== DEC_NONE)) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_vme

  function automatic vme_cycle_t cyc(logic w, logic p, logic n, logic [5:0] am, logic [31:0] a, decoder_t d);
    return '{start: 1'b1, write: w, post: p, narrow: n, am: am, addr: a, decoder: d};
  endfunction : cyc

  function automatic vme_cycle_t miss();
    vme_cycle_t c;
    c = '0;
    c.decoder = DEC_NONE;
    return c;
  endfunction : miss

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stand one cycle only, then the port returns to zero.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_word(what, exp, reg_rdata_o);
    @(posedge ref_clk_i);
    #1;
    check_word("read idle", 32'h0, reg_rdata_o);
  endtask : rd_chk

  // Write, then read the same register on the very next cycle, as the bus allows.
  task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input string what);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_word(what, d, reg_rdata_o);
    @(posedge ref_clk_i);
    #1;
    check_word("read idle", 32'h0, reg_rdata_o);
  endtask : wr_rd_chk

  // Offers one local cycle, judges the decode, then the slave model's tally.
  task automatic offer(input logic [31:0] a, input logic w, input vme_cycle_t exp, input string what);
    @(posedge ref_clk_i);
    local_i <= '{valid: 1'b1, write: w, addr: a};
    @(posedge ref_clk_i);
    local_i.valid <= 1'b0;
    #1;
    check_vme(what, exp, vme_o);
    @(posedge ref_clk_i);
    #1;
    exp_starts += int'(exp.start);
    check_word("slave tally", 32'(exp_starts), taken);
  endtask : offer

  task automatic pulse_reset();
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    exp_starts = 0;
  endtask : pulse_reset

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_regs();
    wr(SEG1_BOUNDS_OFS, 32'h1234_5678);
    rd_chk(SEG1_BOUNDS_OFS, 32'h1234_5678, "seg1 bounds");
    wr(SEG4_XLAT_OFS, 32'hffff_0001);
    rd_chk(SEG4_XLAT_OFS, 32'hffff_0001, "seg4 translation");
    wr_rd_chk(SEG_ATTR_OFS, 32'hc3a5_7e81, "attributes");
    wr(MAP_CONTROL_OFS, 32'hffff_ffff);
    rd_chk(MAP_CONTROL_OFS, 32'h000f_ff00, "control");
    wr(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'h0, "unmapped");
    pulse_reset();
    for (int a = 'h14; a <= 'h2c; a += 4) begin
      rd_chk(8'(a), 32'h0, "reset value");
    end
  endtask : t_regs

  // Ranges never overlap and only single-cycle modifier codes are loaded.
  task automatic t_segments();
    wr(SEG1_BOUNDS_OFS, 32'h1001_1000);
    wr(SEG2_BOUNDS_OFS, 32'h2000_2000);
    wr(SEG3_BOUNDS_OFS, 32'h3000_3000);
    wr(SEG_ATTR_OFS, 32'h003d_8d49);
    offer(32'h1000_0004, 1'b1, miss(), "seg1 off");
    wr(MAP_CONTROL_OFS, 32'h0007_0000);
    offer(32'h1000_0004, 1'b1, cyc(1, 1, 0, 6'h09, 32'h1000_0004, DEC_SEG1), "seg1 low");
    offer(32'h1001_fffc, 1'b0, cyc(0, 0, 0, 6'h09, 32'h1001_fffc, DEC_SEG1), "seg1 top");
    offer(32'h0fff_fffc, 1'b1, miss(), "below seg1");
    offer(32'h1002_0000, 1'b1, miss(), "above seg1");
    offer(32'h2000_ff00, 1'b1, cyc(1, 0, 1, 6'h0d, 32'h2000_ff00, DEC_SEG2), "seg2");
    offer(32'h3000_0000, 1'b0, cyc(0, 0, 0, 6'h3d, 32'h3000_0000, DEC_SEG3), "seg3");
  endtask : t_segments

  task automatic t_translate();
    pulse_reset();
    wr(SEG1_BOUNDS_OFS, 32'hab12_ab12);
    wr(SEG4_BOUNDS_OFS, 32'h40ff_4000);
    wr(SEG4_XLAT_OFS, 32'hab00_ff00);
    wr(SEG_ATTR_OFS, 32'h0900_0049);
    wr(MAP_CONTROL_OFS, 32'h0009_0000);
    offer(32'h4012_5678, 1'b1, cyc(1, 0, 0, 6'h09, 32'hab12_5678, DEC_SEG4), "seg4 mapped");
    offer(32'hab12_5678, 1'b1, cyc(1, 1, 0, 6'h09, 32'hab12_5678, DEC_SEG1), "seg1 alias");
    wr(SEG4_XLAT_OFS, 32'h0001_8001);
    offer(32'h4012_5678, 1'b1, cyc(1, 0, 0, 6'h09, 32'h4013_5678, DEC_SEG4), "seg4 edge bits");
    wr(SEG4_XLAT_OFS, 32'h0);
    offer(32'h4012_5678, 1'b1, cyc(1, 0, 0, 6'h09, 32'h4012_5678, DEC_SEG4), "seg4 plain");
  endtask : t_translate

  task automatic t_short_io();
    pulse_reset();
    offer(32'hffff_0010, 1'b1, miss(), "short io off");
    wr(MAP_CONTROL_OFS, 32'h0000_0f00);
    offer(32'hffff_0010, 1'b1, cyc(1, 1, 1, AM_A16_SUPER, 32'h0000_0010, DEC_SHORT_IO), "sio super");
    wr(MAP_CONTROL_OFS, 32'h0000_0800);
    offer(32'hffff_fffe, 1'b1, cyc(1, 0, 0, AM_A16_USER, 32'h0000_fffe, DEC_SHORT_IO), "sio user");
    offer(32'hfffe_fffe, 1'b1, miss(), "below sio");
  endtask : t_short_io

  task automatic t_page_f();
    wr(MAP_CONTROL_OFS, 32'h0000_e000);
    offer(32'hf012_3456, 1'b1, cyc(1, 1, 1, AM_A24_SUPER, 32'h0012_3456, DEC_PAGE_F), "pf a24");
    offer(32'hf100_0000, 1'b0, cyc(0, 0, 1, AM_A32_SUPER, 32'hf100_0000, DEC_PAGE_F), "pf a32");
    wr(MAP_CONTROL_OFS, 32'h0000_8000);
    offer(32'hf0ff_fffc, 1'b1, cyc(1, 0, 1, AM_A24_USER, 32'h00ff_fffc, DEC_PAGE_F), "pf no post");
    offer(32'hff7f_fffc, 1'b1, cyc(1, 0, 1, AM_A32_USER, 32'hff7f_fffc, DEC_PAGE_F), "pf top");
    wr(MAP_CONTROL_OFS, 32'h0);
    offer(32'hf000_0000, 1'b1, miss(), "pf off");
  endtask : t_page_f

  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // Clock, main sequence and watchdog.
  // ----------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    rstn_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    local_i = '0;
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_segments();
    t_translate();
    t_short_io();
    t_page_f();
    report_and_stop();
  end

  // The tests need well under a thousand cycles; this span leaves ample slack for a hang.
  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end
endmodule : local_to_vme_map_decode_tb

// file: bench/vme_slave_model.sv
/*
  Model of the off-board VMEbus slaves that the map decode stage addresses.
  Counts every claimed cycle and keeps the last one for the bench to inspect.
  Assumes the registered cycle from the decode stage on the shared clock.
*/
module vme_slave_model
  import map_decode_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire vme_cycle_t vme_i,
  output logic [31:0] taken_o,
  output vme_cycle_t last_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A cycle is taken only on a start pulse; a start that stands longer would be counted twice.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      taken_o <= 32'h0;
      last_o <= '0;
    end else if (vme_i.start) begin
      taken_o <= taken_o + 32'h1;
      last_o <= vme_i;
    end
  end
endmodule : vme_slave_model

// file: rtl/local_to_vme_map_decode.sv
/*
  Outbound map decode stage: six local-to-VMEbus decoders (four programmable
  segments, two fixed I/O windows) with their register file, producing the
  VMEbus address, modifier, width and posting attribute one cycle after a
  local cycle is offered. Assumes the cycle engine consumes the registered
  result and that register port accesses are single-cycle strobes.
*/
// Implementation choice: the plain strobed port.
module local_to_vme_map_decode
  import map_decode_pkg::*;
#(
  parameter int SEGMENTS = 4
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire local_cycle_t local_i,
  output vme_cycle_t vme_o
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SEGMENTS-1:0][15:0] start_upper;
    logic [SEGMENTS-1:0][15:0] end_upper;
    logic [SEGMENTS-1:0][7:0] attr;
    logic [15:0] xlat_value;
    logic [15:0] xlat_mask;
    logic [SEGMENTS-1:0] seg_on;
    logic [7:0] io_control;
    logic [31:0] rdata;
    vme_cycle_t vme;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Segment bounds test on the upper address half only.
  function automatic logic seg_hit(input logic on, input logic [15:0] lo,
                                   input logic [15:0] hi, input logic [15:0] a);
    seg_hit = on && (a >= lo) && (a <= hi);
  endfunction : seg_hit

  // Merge translation value into the upper address where selected.
  function automatic logic [15:0] translate(input logic [15:0] value,
                                            input logic [15:0] mask,
                                            input logic [15:0] a);
    translate = (value & mask) | (a & ~mask);
  endfunction : translate

  logic [15:0] up;
  logic short_io_on;
  logic page_f_on;
  logic [7:0] attr_sel;
  logic [SEGMENTS-1:0] hits;

  assign up = local_i.addr[31:16];
  assign short_io_on = state_reg.io_control[SHORT_IO_ON_BIT];
  assign page_f_on = state_reg.io_control[PAGE_F_ON_BIT];

  // ----------------------------------------------------------------------
  // Next-state logic: register port and decode.
  // ----------------------------------------------------------------------
  // Register writes land first; a decode in the same cycle still sees the
  // old settings, which keeps the decode path free of the write data.
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;
    hits = '0;
    attr_sel = ATTR_RESET;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        SEG1_BOUNDS_OFS, SEG2_BOUNDS_OFS, SEG3_BOUNDS_OFS, SEG4_BOUNDS_OFS: begin
          state_next.end_upper[reg_addr_i[3:2] - 2'd1] = reg_wdata_i[END_LSB +: 16];
          state_next.start_upper[reg_addr_i[3:2] - 2'd1] = reg_wdata_i[START_LSB +: 16];
        end
        SEG4_XLAT_OFS: begin
          state_next.xlat_value = reg_wdata_i[XLAT_VALUE_LSB +: 16];
          state_next.xlat_mask = reg_wdata_i[XLAT_MASK_LSB +: 16];
        end
        SEG_ATTR_OFS: state_next.attr = reg_wdata_i;
        MAP_CONTROL_OFS: begin
          state_next.seg_on = reg_wdata_i[SEG_ENABLE_LSB +: SEGMENTS];
          state_next.io_control = reg_wdata_i[IO_CONTROL_LSB +: 8];
        end
        default: ; // Unmapped writes are ignored.
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        SEG1_BOUNDS_OFS, SEG2_BOUNDS_OFS, SEG3_BOUNDS_OFS, SEG4_BOUNDS_OFS:
          state_next.rdata = {state_reg.end_upper[reg_addr_i[3:2] - 2'd1],
                              state_reg.start_upper[reg_addr_i[3:2] - 2'd1]};
        SEG4_XLAT_OFS: state_next.rdata = {state_reg.xlat_value, state_reg.xlat_mask};
        SEG_ATTR_OFS: state_next.rdata = state_reg.attr;
        MAP_CONTROL_OFS: state_next.rdata = {12'h000, state_reg.seg_on, state_reg.io_control, 8'h00};
        default: state_next.rdata = 32'h0000_0000; // Unmapped reads return zero.
      endcase
    end

    // Decode: a fresh result every cycle, start only on a claimed cycle.
    state_next.vme = '0;
    state_next.vme.decoder = DEC_NONE;
    state_next.vme.write = local_i.write;
    for (int i = 0; i < SEGMENTS; i++) begin
      hits[i] = seg_hit(state_reg.seg_on[i], state_reg.start_upper[i], state_reg.end_upper[i], up);
    end
    if (local_i.valid) begin
      // Fixed priority only resolves illegal overlaps deterministically.
      if (short_io_on && up == SHORT_IO_PAGE) begin
        state_next.vme.start = 1'b1;
        state_next.vme.decoder = DEC_SHORT_IO;
        state_next.vme.addr = {16'h0000, local_i.addr[15:0]};
        state_next.vme.am = state_reg.io_control[SHORT_IO_SUPER_BIT] ? AM_A16_SUPER : AM_A16_USER;
        state_next.vme.narrow = state_reg.io_control[SHORT_IO_NARROW_BIT];
        state_next.vme.post = local_i.write && state_reg.io_control[SHORT_IO_POST_BIT];
      end else if (page_f_on && local_i.addr[31:24] == PAGE_F_A24_TOP) begin
        state_next.vme.start = 1'b1;
        state_next.vme.decoder = DEC_PAGE_F;
        state_next.vme.addr = {8'h00, local_i.addr[23:0]};
        state_next.vme.am = state_reg.io_control[PAGE_F_SUPER_BIT] ? AM_A24_SUPER : AM_A24_USER;
        state_next.vme.narrow = 1'b1;
        state_next.vme.post = local_i.write && state_reg.io_control[PAGE_F_POST_BIT];
      end else if (page_f_on && up >= PAGE_F_A32_LOW && up <= PAGE_F_A32_HIGH) begin
        state_next.vme.start = 1'b1;
        state_next.vme.decoder = DEC_PAGE_F;
        state_next.vme.addr = local_i.addr;
        state_next.vme.am = state_reg.io_control[PAGE_F_SUPER_BIT] ? AM_A32_SUPER : AM_A32_USER;
        state_next.vme.narrow = 1'b1;
        state_next.vme.post = local_i.write && state_reg.io_control[PAGE_F_POST_BIT];
      end else begin
        for (int i = SEGMENTS - 1; i >= 0; i--) begin
          if (hits[i]) begin
            attr_sel = state_reg.attr[i];
            state_next.vme.start = 1'b1;
            state_next.vme.decoder = decoder_t'(i);
            state_next.vme.addr = local_i.addr;
            if (i == SEGMENTS - 1) begin
              state_next.vme.addr[31:16] = translate(state_reg.xlat_value, state_reg.xlat_mask, up);
            end
          end
        end
        state_next.vme.am = attr_sel[5:0];
        state_next.vme.narrow = attr_sel[ATTR_NARROW_BIT];
        state_next.vme.post = local_i.write && attr_sel[ATTR_POST_BIT];
      end
    end
    // No claim leaves start low so another responder can take the cycle.
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  // Synchronous reset clears every segment register and control bit.
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
      state_reg.vme.decoder <= DEC_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign reg_rdata_o = state_reg.rdata;
  assign vme_o = state_reg.vme;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_unclaimed_quiet;
    !local_i.valid |=> !vme_o.start;
  endproperty
  a_unclaimed_quiet: assert property (p_unclaimed_quiet) else $error("Start without a local cycle.");

  property p_short_io_window;
    local_i.valid && up == SHORT_IO_PAGE && short_io_on |=>
      vme_o.start && vme_o.decoder == DEC_SHORT_IO && vme_o.addr[31:16] == 16'h0000
      && vme_o.narrow == $past(state_reg.io_control[SHORT_IO_NARROW_BIT]);
  endproperty
  a_short_io_window: assert property (p_short_io_window) else $error("Short I/O window decode wrong.");

  property p_short_io_am;
    vme_o.decoder == DEC_SHORT_IO |->
      vme_o.am == ($past(state_reg.io_control[SHORT_IO_SUPER_BIT]) ? AM_A16_SUPER : AM_A16_USER);
  endproperty
  a_short_io_am: assert property (p_short_io_am) else $error("Short I/O modifier wrong.");

  property p_page_f_narrow;
    vme_o.decoder == DEC_PAGE_F |-> vme_o.narrow && $past(page_f_on);
  endproperty
  a_page_f_narrow: assert property (p_page_f_narrow) else $error("Page F width or enable wrong.");

  property p_page_f_space;
    local_i.valid && page_f_on && local_i.addr[31:24] == PAGE_F_A24_TOP |=>
      vme_o.start && (vme_o.am == AM_A24_SUPER || vme_o.am == AM_A24_USER);
  endproperty
  a_page_f_space: assert property (p_page_f_space) else $error("Page F A24 modifier wrong.");

  property p_fixed_post;
    vme_o.post && vme_o.decoder == DEC_SHORT_IO |-> vme_o.write && $past(state_reg.io_control[SHORT_IO_POST_BIT]);
  endproperty
  a_fixed_post: assert property (p_fixed_post) else $error("Short I/O posted without post bit.");

  property p_seg_enabled;
    // Index with today's decoder; a past index would pick the previous cycle's segment.
    vme_o.start && vme_o.decoder < DEC_SHORT_IO |->
      |($past(state_reg.seg_on) & (SEGMENTS'(1) << vme_o.decoder[1:0]));
  endproperty
  a_seg_enabled: assert property (p_seg_enabled) else $error("Disabled segment claimed a cycle.");

  property p_seg_bounds;
    vme_o.decoder == DEC_SEG1 |-> $past(up) >= $past(state_reg.start_upper[0])
      && $past(up) <= $past(state_reg.end_upper[0]);
  endproperty
  a_seg_bounds: assert property (p_seg_bounds) else $error("Segment one claimed outside its bounds.");

  property p_seg_attr;
    vme_o.decoder == DEC_SEG2 |-> vme_o.am == $past(state_reg.attr[1][5:0])
      && vme_o.narrow == $past(state_reg.attr[1][ATTR_NARROW_BIT])
      && vme_o.post == ($past(local_i.write) && $past(state_reg.attr[1][ATTR_POST_BIT]));
  endproperty
  a_seg_attr: assert property (p_seg_attr) else $error("Segment attributes not applied.");

  property p_translate;
    vme_o.decoder == DEC_SEG4 |-> vme_o.addr[31:16] ==
      (($past(state_reg.xlat_value) & $past(state_reg.xlat_mask)) | ($past(up) & ~$past(state_reg.xlat_mask)));
  endproperty
  a_translate: assert property (p_translate) else $error("Segment four translation wrong.");

  property p_no_translate_low;
    vme_o.decoder == DEC_SEG1 |-> vme_o.addr == $past(local_i.addr);
  endproperty
  a_no_translate_low: assert property (p_no_translate_low) else $error("Segment one address altered.");

  property p_read_slot;
    !reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_read_slot: assert property (p_read_slot) else $error("Read data outside its slot.");

  property p_attr_readback;
    reg_wr_i && reg_addr_i == SEG_ATTR_OFS ##1 reg_rd_i && reg_addr_i == SEG_ATTR_OFS |=>
      reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_attr_readback: assert property (p_attr_readback) else $error("Attribute readback wrong.");

  property p_reset_clears;
    $rose(rstn_i) |-> state_reg.seg_on == '0 && state_reg.attr == '0 && state_reg.xlat_mask == 16'h0000;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("Registers not cleared by reset.");

  c_short_io: cover property (vme_o.start && vme_o.decoder == DEC_SHORT_IO);
  c_page_f_a32: cover property (vme_o.start && vme_o.decoder == DEC_PAGE_F && vme_o.am == AM_A32_USER);
  c_seg4_xlat: cover property (vme_o.start && vme_o.decoder == DEC_SEG4 && state_reg.xlat_mask != 16'h0000);
  c_posted: cover property (vme_o.start && vme_o.post && vme_o.decoder < DEC_SHORT_IO);

endmodule : local_to_vme_map_decode

// file: rtl/map_decode_pkg.sv
/*
  Package for the local-bus-to-VMEbus map decode stage: register offsets,
  field positions, reset values, address modifier codes and carrier types.
  Assumes a single clock and synchronous reset shared with the register port.
*/
package map_decode_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the register port).
  // ----------------------------------------------------------------------
  localparam logic [7:0] SEG1_BOUNDS_OFS = 8'h14;
  localparam logic [7:0] SEG2_BOUNDS_OFS = 8'h18;
  localparam logic [7:0] SEG3_BOUNDS_OFS = 8'h1c;
  localparam logic [7:0] SEG4_BOUNDS_OFS = 8'h20;
  localparam logic [7:0] SEG4_XLAT_OFS = 8'h24;
  localparam logic [7:0] SEG_ATTR_OFS = 8'h28;
  localparam logic [7:0] MAP_CONTROL_OFS = 8'h2c;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int END_LSB = 16;
  localparam int START_LSB = 0;
  localparam int XLAT_VALUE_LSB = 16;
  localparam int XLAT_MASK_LSB = 0;
  localparam int ATTR_NARROW_BIT = 7;
  localparam int ATTR_POST_BIT = 6;
  localparam int SEG_ENABLE_LSB = 16;
  localparam int IO_CONTROL_LSB = 8;
  localparam int PAGE_F_ON_BIT = 7;
  localparam int PAGE_F_POST_BIT = 6;
  localparam int PAGE_F_SUPER_BIT = 5;
  localparam int SHORT_IO_ON_BIT = 3;
  localparam int SHORT_IO_NARROW_BIT = 2;
  localparam int SHORT_IO_POST_BIT = 1;
  localparam int SHORT_IO_SUPER_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and fixed window bounds.
  // ----------------------------------------------------------------------
  localparam logic [15:0] BOUND_RESET = 16'h0000;
  localparam logic [7:0] ATTR_RESET = 8'h00;
  localparam logic [15:0] SHORT_IO_PAGE = 16'hffff;
  localparam logic [7:0] PAGE_F_A24_TOP = 8'hf0;
  localparam logic [15:0] PAGE_F_A32_LOW = 16'hf100;
  localparam logic [15:0] PAGE_F_A32_HIGH = 16'hff7f;

  // ----------------------------------------------------------------------
  // Address modifier codes for the fixed windows.
  // ----------------------------------------------------------------------
  localparam logic [5:0] AM_A16_SUPER = 6'h2d;
  localparam logic [5:0] AM_A16_USER = 6'h29;
  localparam logic [5:0] AM_A24_SUPER = 6'h3d;
  localparam logic [5:0] AM_A24_USER = 6'h39;
  localparam logic [5:0] AM_A32_SUPER = 6'h0d;
  localparam logic [5:0] AM_A32_USER = 6'h09;

  // Index of the decoder that claimed a cycle.
  typedef enum logic [2:0] {
    DEC_SEG1, DEC_SEG2, DEC_SEG3, DEC_SEG4, DEC_SHORT_IO, DEC_PAGE_F, DEC_NONE
  } decoder_t;

  // A local bus cycle offered for decode.
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } local_cycle_t;

  // A VMEbus master cycle handed to the cycle engine.
  typedef struct packed {
    logic start;
    logic write;
    logic post;
    logic narrow;
    logic [5:0] am;
    logic [31:0] addr;
    decoder_t decoder;
  } vme_cycle_t;

endpackage : map_decode_pkg
